//--- shared/tplt_pkg.sv
// Purpose: constants and types shared by the tap pulse timing block
// Assumes: 20 MHz system clock, register offsets as seen over the serial port
// Notes:   time steps are powers of two of the 0.625 ms base step
package tplt_pkg;

  localparam logic [7:0] PULSE_TIME_LIMIT_OFS    = 8'h26;
  localparam logic [7:0] PULSE_LATENCY_OFS       = 8'h27;
  localparam logic [7:0] SECOND_PULSE_WINDOW_OFS = 8'h28;

  localparam logic [7:0] PULSE_TIME_LIMIT_RST    = 8'h00;
  localparam logic [7:0] PULSE_LATENCY_RST       = 8'h00;
  localparam logic [7:0] SECOND_PULSE_WINDOW_RST = 8'h00;

  localparam int CLK_PERIOD_NS  = 50;
  localparam int BASE_STEP_NS   = 625000;
  localparam int BASE_STEP_CYC  = BASE_STEP_NS / CLK_PERIOD_NS;
  localparam int PRE_W          = 14;
  localparam int DIV_W          = 10;
  localparam int AXES           = 3;

  // per-mode caps on the pulse time limit step exponent (units of base step)
  localparam logic [3:0] CAP_HPF_NORMAL = 4'h5;
  localparam logic [3:0] CAP_HPF_LNLP   = 4'h7;
  localparam logic [3:0] CAP_HPF_HIRES  = 4'h2;
  localparam logic [3:0] CAP_HPF_LOWPWR = 4'h8;
  localparam logic [3:0] CAP_RAW_NORMAL = 4'h3;
  localparam logic [3:0] CAP_RAW_LNLP   = 4'h5;
  localparam logic [3:0] CAP_RAW_HIRES  = 4'h0;
  localparam logic [3:0] CAP_RAW_LOWPWR = 4'h6;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_LNLP,
    MODE_HIRES,
    MODE_LOWPWR
  } tplt_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRST,
    ST_LATENCY,
    ST_WINDOW,
    ST_SECOND,
    ST_HOLD
  } tplt_state_e;

  // number of rate halvings below 800 Hz for each output_data_rate code
  function automatic logic [3:0] tplt_halvings(input logic [2:0] rate);
    logic [3:0] h;
    h = 4'h0;
    case (rate)
      3'h0: h = 4'h0;
      3'h1: h = 4'h1;
      3'h2: h = 4'h2;
      3'h3: h = 4'h3;
      3'h4: h = 4'h4;
      3'h5: h = 4'h6;
      3'h6: h = 4'h7;
      default: h = 4'h9;
    endcase
    return h;
  endfunction

endpackage

//--- logic/tplt_core.sv
// Purpose: timing limits of the tap pulse engine: time limit, latency, window
// Assumes: inputs synchronous to sys_clk_i, register port strobes one cycle wide
// Notes:   accel magnitudes are 8 g range counts, compared to 7-bit thresholds
`timescale 1ns/1ps
module tplt_core #(
  parameter int BASE_CYC = tplt_pkg::BASE_STEP_CYC
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [2:0]       output_data_rate_i,
  input  wire logic [1:0]       oversampling_power_mode_i,
  input  wire logic             highpass_enable_i,
  input  wire logic [2:0][7:0]  accel_mag_i,
  input  wire logic [2:0][6:0]  threshold_i,
  output logic      [7:0]       reg_rdata_o,
  output logic                  single_pulse_o,
  output logic                  double_pulse_o
);

  typedef struct packed {
    logic [7:0]              time_limit;
    logic [7:0]              latency;
    logic [7:0]              window;
    tplt_pkg::tplt_state_e   state;
    logic [7:0]              cnt;
    logic [tplt_pkg::PRE_W-1:0] pre;
    logic [tplt_pkg::DIV_W-1:0] div;
    logic [7:0]              rdata;
    logic                    single;
    logic                    double;
  } tplt_regs_s;

  localparam logic [tplt_pkg::PRE_W-1:0] PRE_LAST = tplt_pkg::PRE_W'(BASE_CYC - 1);

  tplt_regs_s       r;
  tplt_regs_s       next_r;
  logic [2:0]       axis_above;
  logic             above;
  logic [3:0]       halv;
  logic [3:0]       exp_t;
  logic [3:0]       exp_l;
  logic [3:0]       cap;
  logic [tplt_pkg::DIV_W-1:0] mask_t;
  logic [tplt_pkg::DIV_W-1:0] mask_l;
  logic             base_tick;
  logic             tick_t;
  logic             tick_l;

  // per-axis magnitude against that axis's own 7-bit threshold_i input
  for (genvar a = 0; a < tplt_pkg::AXES; a++) begin : g_axis
    assign axis_above[a] = accel_mag_i[a] > {1'b0, threshold_i[a]};
  end
  assign above = |axis_above;

  // step exponents; latency and window always run one octave above the limit
  always_comb begin
    halv  = tplt_pkg::tplt_halvings(output_data_rate_i);
    exp_t = 4'h0;
    cap   = tplt_pkg::CAP_HPF_LOWPWR;
    if (highpass_enable_i) begin
      exp_t = halv + 4'h1;
      case (tplt_pkg::tplt_mode_e'(oversampling_power_mode_i))
        tplt_pkg::MODE_NORMAL: cap = tplt_pkg::CAP_HPF_NORMAL;
        tplt_pkg::MODE_LNLP:   cap = tplt_pkg::CAP_HPF_LNLP;
        tplt_pkg::MODE_HIRES:  cap = tplt_pkg::CAP_HPF_HIRES;
        default:               cap = tplt_pkg::CAP_HPF_LOWPWR;
      endcase
    end else begin
      // low power keeps its step at 400 Hz, the others bottom out at base
      case (tplt_pkg::tplt_mode_e'(oversampling_power_mode_i))
        tplt_pkg::MODE_NORMAL: begin
          exp_t = (halv == 4'h0) ? 4'h0 : halv - 4'h1;
          cap   = tplt_pkg::CAP_RAW_NORMAL;
        end
        tplt_pkg::MODE_LNLP: begin
          exp_t = (halv == 4'h0) ? 4'h0 : halv - 4'h1;
          cap   = tplt_pkg::CAP_RAW_LNLP;
        end
        tplt_pkg::MODE_HIRES: begin
          exp_t = tplt_pkg::CAP_RAW_HIRES;
          cap   = tplt_pkg::CAP_RAW_HIRES;
        end
        default: begin
          exp_t = halv;
          cap   = tplt_pkg::CAP_RAW_LOWPWR;
        end
      endcase
    end
    // one shared cap on exp_t; latency and window steps saturate one octave above the time limit step
    if (exp_t > cap) begin
      exp_t = cap;
    end
    exp_l = exp_t + 4'h1;
  end

  assign mask_t    = (tplt_pkg::DIV_W'(1) << exp_t) - tplt_pkg::DIV_W'(1);
  assign mask_l    = (tplt_pkg::DIV_W'(1) << exp_l) - tplt_pkg::DIV_W'(1);
  assign base_tick = (r.pre == PRE_LAST);
  // one shared divider keeps all steps phase aligned; first step may be short
  assign tick_t    = base_tick && ((r.div & mask_t) == '0);
  assign tick_l    = base_tick && ((r.div & mask_l) == '0);

  always_comb begin
    next_r        = r;
    next_r.single = 1'b0;
    next_r.double = 1'b0;
    if (base_tick) begin
      next_r.pre = '0;
      next_r.div = r.div + tplt_pkg::DIV_W'(1);
    end else begin
      next_r.pre = r.pre + tplt_pkg::PRE_W'(1);
    end

    if (reg_wr_i) begin
      if (reg_addr_i == tplt_pkg::PULSE_TIME_LIMIT_OFS) begin
        next_r.time_limit = reg_wdata_i;
      end else if (reg_addr_i == tplt_pkg::PULSE_LATENCY_OFS) begin
        next_r.latency = reg_wdata_i;
      end else if (reg_addr_i == tplt_pkg::SECOND_PULSE_WINDOW_OFS) begin
        next_r.window = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == tplt_pkg::PULSE_TIME_LIMIT_OFS) begin
        next_r.rdata = r.time_limit;
      end else if (reg_addr_i == tplt_pkg::PULSE_LATENCY_OFS) begin
        next_r.rdata = r.latency;
      end else if (reg_addr_i == tplt_pkg::SECOND_PULSE_WINDOW_OFS) begin
        next_r.rdata = r.window;
      end else begin
        next_r.rdata = 8'h00;
      end
    end

    case (r.state)
      tplt_pkg::ST_IDLE: begin
        if (above) begin
          next_r.cnt   = 8'h00;
          next_r.state = tplt_pkg::ST_FIRST;
        end
      end
      tplt_pkg::ST_FIRST: begin
        if (r.cnt == r.time_limit) begin
          next_r.state = tplt_pkg::ST_HOLD;
        end else if (!above) begin
          next_r.single = 1'b1;
          next_r.cnt    = 8'h00;
          next_r.state  = tplt_pkg::ST_LATENCY;
        end else if (tick_t) begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      tplt_pkg::ST_LATENCY: begin
        // pulse starts are deliberately not looked at here
        if (r.cnt == r.latency) begin
          next_r.cnt   = 8'h00;
          next_r.state = tplt_pkg::ST_WINDOW;
        end else if (tick_l) begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      tplt_pkg::ST_WINDOW: begin
        if (r.cnt == r.window) begin
          next_r.state = tplt_pkg::ST_IDLE;
        end else if (above) begin
          next_r.cnt   = 8'h00;
          next_r.state = tplt_pkg::ST_SECOND;
        end else if (tick_l) begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      tplt_pkg::ST_SECOND: begin
        // end of the second pulse may fall after the window closed
        if (r.cnt == r.time_limit) begin
          next_r.state = tplt_pkg::ST_HOLD;
        end else if (!above) begin
          next_r.double = 1'b1;
          next_r.state  = tplt_pkg::ST_IDLE;
        end else if (tick_t) begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      default: begin
        // an over-long excursion must end before a new one can start
        if (!above) begin
          next_r.state = tplt_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r            <= '0;
      r.time_limit <= tplt_pkg::PULSE_TIME_LIMIT_RST;
      r.latency    <= tplt_pkg::PULSE_LATENCY_RST;
      r.window     <= tplt_pkg::SECOND_PULSE_WINDOW_RST;
      r.state      <= tplt_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata_o    = r.rdata;
  assign single_pulse_o = r.single;
  assign double_pulse_o = r.double;

  single_valid_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    r.single |-> $past(r.state) == tplt_pkg::ST_FIRST && !$past(above))
    else $error("single pulse without a short first excursion");
  long_reject_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (r.state == tplt_pkg::ST_FIRST && r.cnt == r.time_limit) |=> r.state == tplt_pkg::ST_HOLD
      ##1 !r.single)
    else $error("over-long pulse not rejected");
  latency_ignore_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (r.state == tplt_pkg::ST_LATENCY && r.cnt != r.latency) |=> r.state == tplt_pkg::ST_LATENCY)
    else $error("latency left early");
  window_start_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (r.state == tplt_pkg::ST_WINDOW && above && r.cnt != r.window)
      |=> r.state == tplt_pkg::ST_SECOND && r.cnt == 8'h00)
    else $error("second pulse start missed");
  window_expire_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (r.state == tplt_pkg::ST_WINDOW && r.cnt == r.window) |=> r.state == tplt_pkg::ST_IDLE)
    else $error("window did not close");
  step_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (r.state == tplt_pkg::ST_LATENCY && r.cnt != r.latency && !tick_l) |=> $stable(r.cnt))
    else $error("latency count moved without a tick");
  reg_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == tplt_pkg::SECOND_PULSE_WINDOW_OFS)
      |=> r.window == $past(reg_wdata_i))
    else $error("window register not written");
  window_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(reg_wr_i && reg_addr_i == tplt_pkg::SECOND_PULSE_WINDOW_OFS) |=> $stable(r.window))
    else $error("window register changed without a write");
  fast_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (highpass_enable_i && output_data_rate_i == 3'h0) |-> exp_t == 4'h1 && exp_l == 4'h2)
    else $error("800 Hz filtered step wrong");
  raw_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!highpass_enable_i && output_data_rate_i == 3'h1 && oversampling_power_mode_i == 2'h0)
      |-> exp_t == 4'h0)
    else $error("400 Hz unfiltered normal step wrong");
  double_src_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    r.double |-> $past(r.state) == tplt_pkg::ST_SECOND && !r.single)
    else $error("double pulse without second excursion");

endmodule

//--- bench/tplt_testbench.sv
// Purpose: self-checking bench for the tap pulse timing block
// Assumes: BASE_CYC of 4, so one 0.625 ms base step lasts four clocks
// Notes:   pulse lengths sit well clear of step edges; the first step may be short
`timescale 1ns/1ps
module testbench;
  logic            sys_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic [7:0]      reg_addr_i = 8'h00;
  logic [7:0]      reg_wdata_i = 8'h00;
  logic            reg_wr_i = 1'b0;
  logic            reg_rd_i = 1'b0;
  logic [2:0]      output_data_rate_i = 3'h0;
  logic [1:0]      oversampling_power_mode_i = 2'h0;
  logic            highpass_enable_i = 1'b1;
  logic [2:0][7:0] accel_mag_i = '0;
  logic [2:0][6:0] threshold_i = {3{7'h10}};
  logic [7:0]      reg_rdata_o;
  logic            single_pulse_o;
  logic            double_pulse_o;
  int              err_total = 0;
  int              total_checks = 0;
  int              n_single = 0;
  int              n_double = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  tplt_core #(.BASE_CYC(4)) dut (
    .sys_clk_i                 (sys_clk_i),
    .rst_i                     (rst_i),
    .reg_addr_i                (reg_addr_i),
    .reg_wdata_i               (reg_wdata_i),
    .reg_wr_i                  (reg_wr_i),
    .reg_rd_i                  (reg_rd_i),
    .output_data_rate_i        (output_data_rate_i),
    .oversampling_power_mode_i (oversampling_power_mode_i),
    .highpass_enable_i         (highpass_enable_i),
    .accel_mag_i               (accel_mag_i),
    .threshold_i               (threshold_i),
    .reg_rdata_o               (reg_rdata_o),
    .single_pulse_o            (single_pulse_o),
    .double_pulse_o            (double_pulse_o)
  );

  // flags last one clock; count them once settled so no edge is missed
  always @(posedge sys_clk_i) begin
    #1;
    if (single_pulse_o === 1'b1) n_single++;
    if (double_pulse_o === 1'b1) n_double++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask

  // one excursion just above threshold, then a quiet tail that bounds the wait
  task automatic pulse(input int ax, input int len, input int tail, output int s, output int d);
    int s0;
    int d0;
    s0 = n_single;
    d0 = n_double;
    @(negedge sys_clk_i);
    accel_mag_i[ax] = 8'h11;
    repeat (len) @(negedge sys_clk_i);
    accel_mag_i[ax] = 8'h10;
    repeat (tail) @(negedge sys_clk_i);
    s = n_single - s0;
    d = n_double - d0;
  endtask

  task automatic t_regs();
    logic [7:0] v;
    for (int i = 0; i < 3; i++) begin
      rd(8'h26 + 8'(i), v);
      check(v, 8'h00, "reset value");
      wr(8'h26 + 8'(i), 8'hA5 ^ 8'(i));
    end
    wr(8'h29, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      rd(8'h26 + 8'(i), v);
      check(v, (i < 3) ? (8'hA5 ^ 8'(i)) : 8'h00, "readback");
    end
    $display("test registers done");
  endtask

  // step per mode in clocks: 8, 1024, 4, 128, 32, 8, 4, 16, 128, 256
  task automatic t_limit();
    int rate[10] = '{0, 7, 2, 7, 6, 0, 1, 3, 4, 5};
    int mode[10] = '{0, 3, 2, 1, 0, 0, 0, 2, 0, 3};
    int hpf[10]  = '{1, 1, 0, 0, 0, 1, 0, 1, 1, 0};
    int lim[10]  = '{3, 2, 3, 2, 3, 0, 3, 3, 2, 2};
    int ok[10]   = '{10, 900, 6, 100, 50, 0, 6, 20, 100, 200};
    int bad[10]  = '{30, 2100, 16, 270, 110, 1, 16, 60, 270, 520};
    int s;
    int d;
    wr(8'h27, 8'h00);
    wr(8'h28, 8'h00);
    for (int i = 0; i < 10; i++) begin
      output_data_rate_i = 3'(rate[i]);
      oversampling_power_mode_i = 2'(mode[i]);
      highpass_enable_i = 1'(hpf[i]);
      wr(8'h26, 8'(lim[i]));
      if (ok[i] > 0) begin
        pulse(i % 3, ok[i], 12, s, d);
        check(8'(s), 8'h01, "short pulse");
      end
      pulse(i % 3, bad[i], 12, s, d);
      check(8'(s), 8'h00, "long pulse");
    end
    $display("test time limit done");
  endtask

  // latency 3 steps of 16 clocks, window 4 steps of 16 clocks
  task automatic t_double();
    int s;
    int d;
    output_data_rate_i = 3'h0;
    oversampling_power_mode_i = 2'h0;
    highpass_enable_i = 1'b1;
    wr(8'h26, 8'h04);
    wr(8'h27, 8'h03);
    wr(8'h28, 8'h04);
    pulse(0, 5, 6, s, d);
    check(8'(s), 8'h01, "first pulse");
    pulse(1, 3, 50, s, d);
    check(8'(s + d), 8'h00, "pulse in latency");
    pulse(2, 5, 12, s, d);
    check(8'(d), 8'h01, "second pulse");
    check(8'(s), 8'h00, "second not single");
    pulse(0, 5, 130, s, d);
    check(8'(s), 8'h01, "first again");
    pulse(0, 5, 130, s, d);
    check(8'(d), 8'h00, "after window");
    check(8'(s), 8'h01, "restart idle");
    $display("test double pulse done");
  endtask

  // a pulse caught in flight by reset must vanish, and the registers return to zero
  task automatic t_reset();
    logic [7:0] v;
    int         s0;
    rd(8'h26, v);
    check(v, 8'h04, "limit before reset");
    s0 = n_single + n_double;
    accel_mag_i[1] = 8'h11;
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    accel_mag_i[1] = 8'h10;
    rst_i = 1'b0;
    check(reg_rdata_o, 8'h00, "read data after reset");
    repeat (12) @(negedge sys_clk_i);
    check(8'(n_single + n_double - s0), 8'h00, "pulse cut by reset");
    for (int i = 0; i < 3; i++) begin
      rd(8'h26 + 8'(i), v);
      check(v, 8'h00, "reset value again");
    end
    $display("test mid-run reset done");
  endtask

  initial begin
    #2ms;
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_regs();
    t_limit();
    t_double();
    t_reset();
    print_verdict();
  end
endmodule
